// ### dual_switch_fault_supervisor.sv
// Contract
// - Missing logic supply clears configuration; outputs still follow direct inputs.
// - Without logic supply, voltage, thermal, current protections run with defaults.
// - Fault indicator goes low on any thermal, load, current or voltage fault.
// - Indicator self-releases when fault clears, except over-current and latched under-voltage.
// - Fault flags held, reported in first valid serial transfer, cleared by it; a read reports the statusSel output only but clears flags of both.
// - Over-temperature detection active only while the output is commanded on.
// - Over-temperature turns output off until cooled; repeats while commanded on.
// - Over-temperature flag stays set until valid read or power reset.
// - Over-voltage holds output off; flag in bit one, cleared by read or reset.
// - A configuration bit disables over-voltage action and its flag.
// - Supply below threshold turns output off, indicator low, under-voltage flag set.
// - Recovery with command off releases indicator; flag stays until next read.
// - Recovery with command on keeps output off until commanded off then on.
// - Under-voltage disable hides reporting; output off only below reset-level supply.
// - Open load detected only while output off, latched once gate is off.
// - Open load flag clears on read once the condition has gone.
// - Eight low and two high trip levels, one of each monitored together.
// - Low trip held beyond programmed delay latches the output off.
// - High trip latches the output off at once, ignoring the delay.
// - Latched output stays off until commanded off then on.
// - Output command counts as on if direct input requests on, or serial bit does while logic supply is present.
`timescale 1ns/1ns
`default_nettype none
module dual_switch_fault_supervisor #(
  parameter int NOUT = fault_sup_pkg::NUM_OUT
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic logicSupplyOk,
  input wire logic [NOUT-1:0] direct_output_inputs,
  input wire logic [NOUT-1:0] serialOnCmd,
  input wire logic overvoltage_disable,
  input wire logic undervoltage_disable,
  input wire logic open_load_disable,
  input wire logic [fault_sup_pkg::TRIP_SEL_W-1:0] low_current_trip_level [NOUT],
  input wire logic [NOUT-1:0] high_current_trip_level,
  input wire logic [fault_sup_pkg::DELAY_SEL_W-1:0] low_trip_delay [NOUT],
  input wire logic [NOUT-1:0] overTempSense,
  input wire logic [NOUT-1:0] openLoadSense,
  input wire logic [NOUT-1:0] lowTripSense [8],
  input wire logic [NOUT-1:0] highTripSense [2],
  input wire logic overVoltSense,
  input wire logic underVoltSense,
  input wire logic belowResetSense,
  input wire logic [NOUT-1:0] statusSel,
  input wire logic readStrobe,
  output logic [NOUT-1:0] outputEnable,
  output logic fault_indicator_n,
  output logic [fault_sup_pkg::ST_W-1:0] statusWord
);
  import fault_sup_pkg::*;

  typedef struct packed {
    logic [NOUT-1:0] en;
    logic faultN;
    logic [ST_W-1:0] status;
    logic [NOUT-1:0] otFlag;
    logic [NOUT-1:0] olFlag;
    logic [NOUT-1:0] ocFlag;
    logic ovFlag;
    logic uvFlag;
    logic uvLatch;
    logic [NOUT-1:0] cmdPrev;
  } top_t;

  top_t st_r;
  top_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Effective configuration, defaults when logic supply is lost
  logic ovDis;
  logic uvDis;
  logic olDis;
  logic [NOUT-1:0] cmdOn;
  logic [NOUT-1:0] lowHit;
  logic [NOUT-1:0] highHit;
  logic [NOUT-1:0] blocked;
  logic [NOUT-1:0] ocLatched;
  logic [NOUT-1:0] otEv;
  logic [NOUT-1:0] olEv;
  logic [NOUT-1:0] ocEv;

  always_comb begin
    ovDis = logicSupplyOk ? overvoltage_disable : 1'b0;
    uvDis = logicSupplyOk ? undervoltage_disable : 1'b0;
    olDis = logicSupplyOk ? open_load_disable : 1'b0;
    cmdOn = direct_output_inputs | (logicSupplyOk ? serialOnCmd : '0);
    for (int i = 0; i < NOUT; i++) begin
      // One low and one high level selected per output
      lowHit[i] = lowTripSense[logicSupplyOk ? low_current_trip_level[i] : TRIP_LOW_DEFAULT][i];
      highHit[i] = highTripSense[logicSupplyOk ? high_current_trip_level[i] : HIGH_TRIP_DEFAULT][i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < NOUT; g++) begin : gChan
      fault_sup_if cif ();
      assign cif.cmdOn = cmdOn[g];
      assign cif.enable = st_r.en[g];
      assign cif.overTemp = overTempSense[g];
      assign cif.openLoad = openLoadSense[g] && !olDis;
      assign cif.lowHit = lowHit[g];
      assign cif.highHit = highHit[g];
      assign cif.delaySel = logicSupplyOk ? low_trip_delay[g] : DELAY_DEFAULT;
      assign blocked[g] = cif.blocked;
      assign ocLatched[g] = cif.ocLatched;
      assign otEv[g] = cif.otEvent;
      assign olEv[g] = cif.olEvent;
      assign ocEv[g] = cif.ocEvent;
      out_channel uChan (
        .mclk(mclk),
        .rst_n(rst_n),
        .ch(cif.chan)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  logic ovActive;
  logic uvActive;
  logic [NOUT-1:0] rise;
  logic [ST_W-1:0] selStatus;

  always_comb begin
    st_nxt = st_r;
    ovActive = overVoltSense && !ovDis;
    uvActive = underVoltSense && !uvDis;
    rise = cmdOn & ~st_r.cmdPrev;
    st_nxt.cmdPrev = cmdOn;
    // Under-voltage with any output commanded on latches until toggled
    if (uvActive && |cmdOn) begin
      st_nxt.uvLatch = 1'b1;
    end else if (!underVoltSense && |rise) begin
      st_nxt.uvLatch = 1'b0;
    end else if (uvDis) begin
      st_nxt.uvLatch = 1'b0;
    end
    for (int i = 0; i < NOUT; i++) begin
      st_nxt.en[i] = cmdOn[i] && !blocked[i] && !ovActive && !uvActive && !st_r.uvLatch
                     && !belowResetSense;
    end
    // Status snapshot for the selected output
    selStatus = ST_RESET;
    for (int i = 0; i < NOUT; i++) begin
      if (statusSel[i]) begin
        selStatus[ST_OVERTEMP] = st_r.otFlag[i];
        selStatus[ST_OPENLOAD] = st_r.olFlag[i];
        selStatus[ST_OCF] = st_r.ocFlag[i];
      end
    end
    selStatus[ST_OVERVOLT] = st_r.ovFlag;
    selStatus[ST_UNDERVOLT] = st_r.uvFlag;
    // Read clears flags; a set in the same cycle wins
    if (readStrobe) begin
      st_nxt.status = selStatus;
      st_nxt.otFlag = '0;
      st_nxt.olFlag = '0;
      st_nxt.ocFlag = '0;
      st_nxt.ovFlag = 1'b0;
      st_nxt.uvFlag = 1'b0;
    end
    st_nxt.otFlag = st_nxt.otFlag | otEv;
    st_nxt.olFlag = st_nxt.olFlag | olEv;
    st_nxt.ocFlag = st_nxt.ocFlag | ocEv;
    st_nxt.ovFlag = st_nxt.ovFlag | ovActive;
    st_nxt.uvFlag = st_nxt.uvFlag | uvActive;
    st_nxt.faultN = !(|otEv || |olEv || |ocLatched || ovActive || uvActive || st_r.uvLatch);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.faultN <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign outputEnable = st_r.en;
  assign fault_indicator_n = st_r.faultN;
  assign statusWord = st_r.status;
endmodule : dual_switch_fault_supervisor
`default_nettype wire

// ### fault_sup_pkg.sv
package fault_sup_pkg;
  localparam int NUM_OUT = 2;
  localparam int TRIP_SEL_W = 3;
  localparam int DELAY_SEL_W = 2;
  localparam int DELAY_CNT_W = 16;
  localparam int CLK_NS = 100;
  // Low trip delay figures in microseconds, per selection code
  localparam int LOW_DELAY_US0 = 150;
  localparam int LOW_DELAY_US1 = 10;
  localparam int LOW_DELAY_US2 = 1000;
  localparam int LOW_DELAY_US3 = 2000;
  localparam logic [DELAY_CNT_W-1:0] LOW_DELAY_CYC0 = DELAY_CNT_W'((LOW_DELAY_US0 * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [DELAY_CNT_W-1:0] LOW_DELAY_CYC1 = DELAY_CNT_W'((LOW_DELAY_US1 * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [DELAY_CNT_W-1:0] LOW_DELAY_CYC2 = DELAY_CNT_W'((LOW_DELAY_US2 * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [DELAY_CNT_W-1:0] LOW_DELAY_CYC3 = DELAY_CNT_W'((LOW_DELAY_US3 * 1000 + CLK_NS - 1) / CLK_NS);
  // Status word field positions
  localparam int ST_OVERTEMP = 0;
  localparam int ST_OVERVOLT = 1;
  localparam int ST_UNDERVOLT = 2;
  localparam int ST_OPENLOAD = 3;
  localparam int ST_OCF = 4;
  localparam int ST_W = 8;
  localparam logic [ST_W-1:0] ST_RESET = 8'h00;
  localparam logic [TRIP_SEL_W-1:0] TRIP_LOW_DEFAULT = 3'h0;
  localparam logic HIGH_TRIP_DEFAULT = 1'h0;
  localparam logic [DELAY_SEL_W-1:0] DELAY_DEFAULT = 2'h0;
endpackage : fault_sup_pkg

// ### fault_sup_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fault_sup_if;
  import fault_sup_pkg::*;
  logic cmdOn;
  logic enable;
  logic overTemp;
  logic openLoad;
  logic lowHit;
  logic highHit;
  logic [DELAY_SEL_W-1:0] delaySel;
  logic blocked;
  logic ocLatched;
  logic otEvent;
  logic olEvent;
  logic ocEvent;
  modport top (output cmdOn, enable, overTemp, openLoad, lowHit, highHit, delaySel,
               input blocked, ocLatched, otEvent, olEvent, ocEvent);
  modport chan (input cmdOn, enable, overTemp, openLoad, lowHit, highHit, delaySel,
                output blocked, ocLatched, otEvent, olEvent, ocEvent);
endinterface : fault_sup_if
`default_nettype wire

// ### out_channel.sv
`timescale 1ns/1ns
`default_nettype none
module out_channel (
  input wire logic mclk,
  input wire logic rst_n,
  fault_sup_if.chan ch
);
  import fault_sup_pkg::*;

  typedef struct packed {
    logic ocLatch;
    logic otOff;
    logic cmdPrev;
    logic [DELAY_CNT_W-1:0] cnt;
  } chan_t;

  chan_t st_r;
  chan_t st_nxt;

  function automatic logic [DELAY_CNT_W-1:0] delayCycles(input logic [DELAY_SEL_W-1:0] sel);
    unique case (sel)
      2'h0: delayCycles = LOW_DELAY_CYC0;
      2'h1: delayCycles = LOW_DELAY_CYC1;
      2'h2: delayCycles = LOW_DELAY_CYC2;
      2'h3: delayCycles = LOW_DELAY_CYC3;
    endcase
  endfunction : delayCycles

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.cmdPrev = ch.cmdOn;
    // Off-to-on command edge rearms a latched output
    if (ch.cmdOn && !st_r.cmdPrev) begin
      st_nxt.ocLatch = 1'b0;
    end
    // Thermal cycling only while commanded on
    st_nxt.otOff = ch.cmdOn && ch.overTemp;
    if (ch.enable && ch.lowHit && !st_r.ocLatch) begin
      if (st_r.cnt >= delayCycles(ch.delaySel)) begin
        st_nxt.ocLatch = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + DELAY_CNT_W'(1);
      end
    end else begin
      st_nxt.cnt = '0;
    end
    if (ch.enable && ch.highHit) begin
      st_nxt.ocLatch = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ch.ocLatched = st_r.ocLatch;
  assign ch.blocked = st_r.ocLatch || st_r.otOff;
  assign ch.otEvent = st_r.otOff;
  assign ch.ocEvent = st_r.ocLatch;
  // Open load only looked at while output is off
  assign ch.olEvent = !ch.enable && ch.openLoad;
endmodule : out_channel
`default_nettype wire

// ### fsup_properties.sv
`timescale 1ns/1ns
`default_nettype none
module fsup_properties #(parameter int NOUT = 2) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic logicSupplyOk,
  input wire logic [NOUT-1:0] direct_output_inputs,
  input wire logic [NOUT-1:0] serialOnCmd,
  input wire logic overvoltage_disable,
  input wire logic undervoltage_disable,
  input wire logic overVoltSense,
  input wire logic underVoltSense,
  input wire logic [NOUT-1:0] overTempSense,
  input wire logic [NOUT-1:0] highTripSense [2],
  input wire logic [NOUT-1:0] high_current_trip_level,
  input wire logic readStrobe,
  input wire logic [NOUT-1:0] outputEnable,
  input wire logic fault_indicator_n,
  input wire logic [fault_sup_pkg::ST_W-1:0] statusWord
);
  import fault_sup_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic ovOn = overVoltSense && !(overvoltage_disable && logicSupplyOk);
  wire logic uvOn = underVoltSense && !(undervoltage_disable && logicSupplyOk);
  wire logic cmd0 = direct_output_inputs[0] | serialOnCmd[0];
  ov_off_a: assert property (ovOn [*2] |-> outputEnable == '0) else $error("output on in overvoltage");
  ov_pin_a: assert property (ovOn [*2] |-> !fault_indicator_n) else $error("pin high in overvoltage");
  uv_off_a: assert property (uvOn [*2] |-> outputEnable == '0 && !fault_indicator_n) else $error("undervoltage");
  ov_flag_a: assert property (ovOn [*3] ##0 readStrobe |=> statusWord[ST_OVERVOLT]) else $error("ov flag lost");
  word_hold_a: assert property (!readStrobe |=> $stable(statusWord)) else $error("status changed");
  hi_trip_a: assert property (highTripSense[logicSupplyOk ? high_current_trip_level[0] : HIGH_TRIP_DEFAULT][0]
    && outputEnable[0] |-> ##[1:3] !outputEnable[0]) else $error("high trip ignored");
  ot_off_a: assert property (overTempSense[0] && outputEnable[0] |-> ##[1:3] !outputEnable[0])
    else $error("overtemp ignored");
  cmd_off_a: assert property (!cmd0 [*3] |-> !outputEnable[0]) else $error("on without command");
  cover property (ovOn ##1 readStrobe);
  cover property ($fell(outputEnable[0]) && overTempSense[0]);
  cover property (uvOn ##1 !underVoltSense);
endmodule : fsup_properties
`default_nettype wire

// ### mcu_model.sv
`timescale 1ns/1ns
`default_nettype none
module mcu_model (
  input wire logic mclk,
  input wire logic [fault_sup_pkg::ST_W-1:0] statusWord,
  output logic readStrobe
);
  import fault_sup_pkg::*;
  initial readStrobe = 1'h0;
  task automatic rd(output logic [ST_W-1:0] s);
    @(posedge mclk) readStrobe <= 1'h1;
    @(posedge mclk) readStrobe <= 1'h0;
    #1 s = statusWord;
  endtask : rd
endmodule : mcu_model
`default_nettype wire

// ### dual_switch_fault_supervisor_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dual_switch_fault_supervisor_tb;
  import fault_sup_pkg::*;
  logic mclk, rst_n, logicSupplyOk, overvoltage_disable, undervoltage_disable, open_load_disable;
  logic overVoltSense, underVoltSense, belowResetSense, readStrobe, fault_indicator_n;
  logic [1:0] direct_output_inputs, serialOnCmd, high_current_trip_level, overTempSense, openLoadSense;
  logic [1:0] statusSel, outputEnable;
  logic [TRIP_SEL_W-1:0] low_current_trip_level [2];
  logic [DELAY_SEL_W-1:0] low_trip_delay [2];
  logic [1:0] lowTripSense [8];
  logic [1:0] highTripSense [2];
  logic [ST_W-1:0] statusWord, s;
  int err_total = 0;
  int check_count = 0;
  dual_switch_fault_supervisor dut_u (.mclk, .rst_n, .logicSupplyOk, .direct_output_inputs, .serialOnCmd,
    .overvoltage_disable, .undervoltage_disable, .open_load_disable, .low_current_trip_level,
    .high_current_trip_level, .low_trip_delay, .overTempSense, .openLoadSense, .lowTripSense, .highTripSense,
    .overVoltSense, .underVoltSense, .belowResetSense, .statusSel, .readStrobe, .outputEnable,
    .fault_indicator_n, .statusWord);
  mcu_model mcu_u (.mclk, .statusWord, .readStrobe);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
  //////////////////////////////////////////////////////////////
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic chk(logic got, logic exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %b exp %b", $time, got, exp);
    end
  endtask : chk
  // Settle, look at output 0 and the pin, return on an edge
  task automatic sw(logic oe, logic fn);
    cyc(3);
    #1;
    chk(outputEnable[0], oe);
    chk(fault_indicator_n, fn);
    cyc(1);
  endtask : sw
  task automatic fl(int idx, logic v);
    mcu_u.rd(s);
    chk(s[idx], v);
    cyc(1);
  endtask : fl
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic t_volt;
    direct_output_inputs <= 2'h1;
    sw(1, 1);
    overVoltSense <= 1'b1;
    sw(0, 0);
    fl(ST_OVERVOLT, 1);
    overVoltSense <= 1'b0;
    sw(1, 1);
    fl(ST_OVERVOLT, 1);
    fl(ST_OVERVOLT, 0);
    overvoltage_disable <= 1'b1;
    overVoltSense <= 1'b1;
    sw(1, 1);
    fl(ST_OVERVOLT, 0);
    logicSupplyOk <= 1'b0;
    sw(0, 0);
    overVoltSense <= 1'b0;
    direct_output_inputs <= 2'h0;
    serialOnCmd <= 2'h1;
    sw(0, 1);
    direct_output_inputs <= 2'h1;
    sw(1, 1);
    {logicSupplyOk, overvoltage_disable, serialOnCmd} <= 4'h8;
    $display("voltage test done");
  endtask : t_volt
  task automatic t_temp;
    overTempSense <= 2'h1;
    sw(0, 0);
    overTempSense <= 2'h0;
    sw(1, 1);
    fl(ST_OVERTEMP, 1);
    direct_output_inputs <= 2'h0;
    overTempSense <= 2'h1;
    sw(0, 1);
    fl(ST_OVERTEMP, 0);
    overTempSense <= 2'h0;
    openLoadSense <= 2'h1;
    sw(0, 0);
    fl(ST_OPENLOAD, 1);
    openLoadSense <= 2'h0;
    sw(0, 1);
    fl(ST_OPENLOAD, 1);
    fl(ST_OPENLOAD, 0);
    open_load_disable <= 1'b1;
    openLoadSense <= 2'h1;
    sw(0, 1);
    fl(ST_OPENLOAD, 0);
    {open_load_disable, openLoadSense} <= 3'h0;
    $display("thermal and load test done");
  endtask : t_temp
  task automatic t_curr;
    direct_output_inputs <= 2'h1;
    low_current_trip_level[0] <= 3'h5;
    low_trip_delay[0] <= 2'h1;
    lowTripSense[5] <= 2'h1;
    cyc(50);
    sw(1, 1);
    cyc(60);
    sw(0, 0);
    lowTripSense[5] <= 2'h0;
    sw(0, 0);
    direct_output_inputs <= 2'h0;
    cyc(3);
    direct_output_inputs <= 2'h1;
    sw(1, 1);
    highTripSense[0] <= 2'h1;
    cyc(2);
    highTripSense[0] <= 2'h0;
    sw(0, 0);
    fl(ST_OCF, 1);
    direct_output_inputs <= 2'h0;
    sw(0, 0);
    $display("current test done");
  endtask : t_curr
  task automatic t_uv;
    serialOnCmd <= 2'h1;
    sw(1, 1);
    underVoltSense <= 1'b1;
    sw(0, 0);
    underVoltSense <= 1'b0;
    sw(0, 0);
    serialOnCmd <= 2'h0;
    cyc(3);
    serialOnCmd <= 2'h1;
    sw(1, 1);
    serialOnCmd <= 2'h0;
    underVoltSense <= 1'b1;
    sw(0, 0);
    underVoltSense <= 1'b0;
    sw(0, 1);
    fl(ST_UNDERVOLT, 1);
    {undervoltage_disable, underVoltSense, serialOnCmd} <= 4'hD;
    sw(1, 1);
    fl(ST_UNDERVOLT, 0);
    belowResetSense <= 1'b1;
    sw(0, 1);
    $display("undervoltage test done");
  endtask : t_uv
  // Output 1 with high level 1 selected; level 0 sense must be ignored
  task automatic t_sel;
    {belowResetSense, underVoltSense, serialOnCmd} <= 4'h0;
    statusSel <= 2'h2;
    high_current_trip_level <= 2'h2;
    direct_output_inputs <= 2'h2;
    highTripSense[0] <= 2'h2;
    cyc(3);
    #1;
    chk(outputEnable[1], 1'b1);
    chk(fault_indicator_n, 1'b1);
    cyc(1);
    highTripSense[1] <= 2'h2;
    cyc(3);
    #1;
    chk(outputEnable[1], 1'b0);
    chk(fault_indicator_n, 1'b0);
    cyc(1);
    fl(ST_OCF, 1);
    $display("selection test done");
  endtask : t_sel
  initial begin
    {overvoltage_disable, undervoltage_disable, open_load_disable, overVoltSense, underVoltSense} = 5'h00;
    {belowResetSense, direct_output_inputs, serialOnCmd, high_current_trip_level} = 7'h00;
    {overTempSense, openLoadSense} = 4'h0;
    low_current_trip_level = '{default: 3'h0};
    low_trip_delay = '{default: 2'h0};
    lowTripSense = '{default: 2'h0};
    highTripSense = '{default: 2'h0};
    statusSel = 2'h1;
    logicSupplyOk = 1'b1;
    rst_n = 1'b0;
    cyc(20);
    rst_n <= 1'b1;
    cyc(1);
    t_volt();
    t_temp();
    t_curr();
    t_uv();
    t_sel();
    end_sim();
  end
endmodule : dual_switch_fault_supervisor_tb
bind dual_switch_fault_supervisor fsup_properties #(.NOUT(NOUT)) prop_u (.mclk, .rst_n, .logicSupplyOk,
  .direct_output_inputs,
  .serialOnCmd, .overvoltage_disable, .undervoltage_disable, .overVoltSense, .underVoltSense, .overTempSense,
  .highTripSense, .high_current_trip_level, .readStrobe, .outputEnable, .fault_indicator_n, .statusWord);
`default_nettype wire
